//--- inc/sme_map.svh
// Register offsets, bit positions and counts for the standby mode entry link.
// Assumes 8-bit device registers and byte addresses on the host's Avalon-MM side.
`ifndef SME_MAP_SVH
`define SME_MAP_SVH
`define SME_A_FLASH0     4'h0
`define SME_A_FLASH2     4'h1
`define SME_A_CTRL1      4'h2
`define SME_A_CTRL3      4'h3
`define SME_A_PROTECT    4'h4
`define SME_A_VOLT       4'h5
`define SME_A_OSC        4'h6
`define SME_B_REWRITE    1
`define SME_B_LOWCUR     7
`define SME_B_STOP       0
`define SME_B_WAIT       0
`define SME_B_UNLOCK     0
`define SME_B_PWR        0
`define SME_B_STABLE     3
`define SME_RST_BIT      1'b0
`define SME_RST_OSD      2'b00
`define SME_PREFETCH     3'h4
`define SME_AV_CTRL      4'h0
`define SME_AV_STAT      4'h4
`define SME_AV_START     0
`define SME_AV_METH_LO   1
`define SME_AV_SLOW      3
`define SME_AV_LOWSPD    4
`endif

//--- inc/sme_pkg.sv
// Types for the two ends of the standby mode entry link, each type used by one end only.
// Assumes the constants of sme_map.svh alongside.
package sme_pkg;
	typedef enum logic [1:0] {SME_STOP, SME_WAIT_REG, SME_WAIT_INSTR} sme_method_e;
	typedef enum {DEV_RUN, DEV_PREFETCH, DEV_HALTED} sme_dev_state_e;
	typedef enum {CPU_IDLE, CPU_STEP, CPU_FETCH, CPU_SLEEP, CPU_POST1, CPU_POST2} sme_cpu_state_e;
endpackage

//--- inc/sme_if.sv
// Link between the CPU core end and the clock control end.
// Assumes both ends run on one clock.
`timescale 1ns/1ns
interface sme_if;
	logic       reg_wr;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       int_enable_flag;
	logic       halt_instr;
	logic       fetch_req;
	logic       fetch_grant;
	logic       cpu_halted;
	logic       refused;
	modport cpu (output reg_wr, reg_addr, reg_wdata, int_enable_flag, halt_instr, fetch_req,
		input fetch_grant, cpu_halted, refused);
	modport clk (input reg_wr, reg_addr, reg_wdata, int_enable_flag, halt_instr, fetch_req,
		output fetch_grant, cpu_halted, refused);
endinterface

//--- rtl/sme_clock_ctrl.sv
// Clock control end: mode registers, stop and wait entry, prefetch and CPU clock gate.
// Assumes the CPU end on the same clock; oscillator status arrives from pins.
`timescale 1ns/1ns
`include "sme_map.svh"
module sme_clock_ctrl (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	sme_if.clk        link,
	input  wire logic wake_irq_in,
	input  wire logic xin_fast_in,
	input  wire logic xin_stable_in,
	output logic       cpu_clk_en_out,
	output logic       stop_mode_out,
	output logic       wait_mode_out,
	output logic       power_reduce_out,
	output logic [1:0] osd_enable_out,
	output logic       osc_stable_out,
	output logic       osc_stop_det_out
);
	sme_pkg::sme_dev_state_e state;
	sme_pkg::sme_dev_state_e next_state;
	logic       rewrite_en;
	logic       next_rewrite_en;
	logic       lowcur_en;
	logic       next_lowcur_en;
	logic       stop_req;
	logic       next_stop_req;
	logic       wait_req;
	logic       next_wait_req;
	logic       in_wait;
	logic       next_in_wait;
	logic       unlock;
	logic       next_unlock;
	logic       pwr_reduce;
	logic       next_pwr_reduce;
	logic [1:0] osd_en;
	logic [1:0] next_osd_en;
	logic [2:0] fetched;
	logic [2:0] next_fetched;
	logic       refused;
	logic       next_refused;
	logic [1:0] fast_sync;
	logic [1:0] stable_sync;
	logic       next_osc_stable;
	logic       next_osc_stop_det;
	logic       flash_idle;

	// Both flash modes must be off before the core may enter wait
	assign flash_idle = !rewrite_en && !lowcur_en;

	always_comb
	begin
		next_state      = state;
		next_rewrite_en = rewrite_en;
		next_lowcur_en  = lowcur_en;
		next_stop_req   = stop_req;
		next_wait_req   = wait_req;
		next_in_wait    = in_wait;
		next_unlock     = unlock;
		next_pwr_reduce = pwr_reduce;
		next_osd_en     = osd_en;
		next_fetched    = fetched;
		next_refused    = 1'b0;
		if (link.reg_wr)
		begin
			case (link.reg_addr)
				`SME_A_FLASH0:  next_rewrite_en = link.reg_wdata[`SME_B_REWRITE];
				`SME_A_FLASH2:  next_lowcur_en = link.reg_wdata[`SME_B_LOWCUR];
				`SME_A_PROTECT: next_unlock = link.reg_wdata[`SME_B_UNLOCK];
				`SME_A_VOLT:    next_pwr_reduce = link.reg_wdata[`SME_B_PWR];
				`SME_A_OSC:     next_osd_en = link.reg_wdata[1:0];
				`SME_A_CTRL1:
				begin
					// Locked or rewrite still on: the request is dropped
					if (!link.reg_wdata[`SME_B_STOP])
						next_stop_req = 1'b0;
					else if (unlock && !rewrite_en && state == sme_pkg::DEV_RUN)
					begin
						next_stop_req = 1'b1;
						next_state    = sme_pkg::DEV_PREFETCH;
						next_fetched  = 3'h0;
					end
					else
						next_refused = 1'b1;
				end
				`SME_A_CTRL3:
				begin
					if (!link.reg_wdata[`SME_B_WAIT])
						next_wait_req = 1'b0;
					else if (unlock && flash_idle && state == sme_pkg::DEV_RUN)
					begin
						next_wait_req = 1'b1;
						next_in_wait  = 1'b1;
						next_state    = sme_pkg::DEV_PREFETCH;
						next_fetched  = 3'h0;
					end
					else
						next_refused = 1'b1;
				end
				default:
				begin
				end
			endcase
		end
		if (link.halt_instr)
		begin
			if (flash_idle && state == sme_pkg::DEV_RUN)
			begin
				next_in_wait = 1'b1;
				next_state   = sme_pkg::DEV_PREFETCH;
				next_fetched = 3'h0;
			end
			else
				next_refused = 1'b1;
		end
		case (state)
			sme_pkg::DEV_PREFETCH:
			begin
				// The queue takes exactly four more bytes, then the core halts
				if (link.fetch_req)
				begin
					next_fetched = fetched + 3'h1;
					if (fetched + 3'h1 == `SME_PREFETCH)
						next_state = sme_pkg::DEV_HALTED;
				end
			end
			sme_pkg::DEV_HALTED:
			begin
				// A wake interrupt restarts fetch and clears the request bits
				if (wake_irq_in)
				begin
					next_state    = sme_pkg::DEV_RUN;
					next_stop_req = 1'b0;
					next_wait_req = 1'b0;
					next_in_wait  = 1'b0;
				end
			end
			default:
			begin
			end
		endcase
		// Detection cannot work on a slow main clock, so it is held off
		if (!fast_sync[1])
			next_osd_en = `SME_RST_OSD;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state      <= sme_pkg::DEV_RUN;
			rewrite_en <= `SME_RST_BIT;
			lowcur_en  <= `SME_RST_BIT;
			stop_req   <= `SME_RST_BIT;
			wait_req   <= `SME_RST_BIT;
			in_wait    <= `SME_RST_BIT;
			unlock     <= `SME_RST_BIT;
			pwr_reduce <= `SME_RST_BIT;
			osd_en     <= `SME_RST_OSD;
			fetched    <= 3'h0;
			refused    <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			rewrite_en <= next_rewrite_en;
			lowcur_en  <= next_lowcur_en;
			stop_req   <= next_stop_req;
			wait_req   <= next_wait_req;
			in_wait    <= next_in_wait;
			unlock     <= next_unlock;
			pwr_reduce <= next_pwr_reduce;
			osd_en     <= next_osd_en;
			fetched    <= next_fetched;
			refused    <= next_refused;
		end
	end

	// Stable status only counts when the main clock is fast enough to judge
	always_comb
	begin
		next_osc_stable   = fast_sync[1] && stable_sync[1];
		next_osc_stop_det = fast_sync[1] && (osd_en != 2'b00) && !stable_sync[1];
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			fast_sync        <= 2'b00;
			stable_sync      <= 2'b00;
			osc_stable_out   <= 1'b0;
			osc_stop_det_out <= 1'b0;
		end
		else
		begin
			fast_sync        <= {fast_sync[0], xin_fast_in};
			stable_sync      <= {stable_sync[0], xin_stable_in};
			osc_stable_out   <= next_osc_stable;
			osc_stop_det_out <= next_osc_stop_det;
		end
	end

	// Core clock is gated only while halted
	assign cpu_clk_en_out   = (state != sme_pkg::DEV_HALTED);
	assign link.cpu_halted  = (state == sme_pkg::DEV_HALTED);
	assign link.fetch_grant = (state != sme_pkg::DEV_HALTED);
	assign link.refused     = refused;
	assign stop_mode_out    = stop_req;
	assign wait_mode_out    = in_wait;
	// Power reduction takes effect only inside wait
	assign power_reduce_out = pwr_reduce && in_wait && (state == sme_pkg::DEV_HALTED);
	assign osd_enable_out   = osd_en;
endmodule // sme_clock_ctrl

//--- rtl/sme_cpu_end.sv
// CPU core end: runs the stop or wait entry program on an Avalon-MM command.
// Assumes the clock control end on the same clock and link.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
`include "sme_map.svh"
module sme_cpu_end (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	sme_if.cpu               link,
	input  wire logic [3:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out
);
	sme_pkg::sme_cpu_state_e state;
	sme_pkg::sme_cpu_state_e next_state;
	sme_pkg::sme_method_e    meth;
	sme_pkg::sme_method_e    next_meth;
	logic        slow;
	logic        next_slow;
	logic        lowspd;
	logic        next_lowspd;
	logic [2:0]  step;
	logic [2:0]  next_step;
	logic [2:0]  fetched;
	logic [2:0]  next_fetched;
	logic        err;
	logic        next_err;
	logic        done;
	logic        next_done;
	logic        wr;
	logic        next_wr;
	logic [3:0]  addr;
	logic [3:0]  next_addr;
	logic [7:0]  wdata;
	logic [7:0]  next_wdata;
	logic        iflag;
	logic        next_iflag;
	logic        halt;
	logic        next_halt;
	logic        ack;
	logic [31:0] next_rdata;
	logic        start;

	// A start takes effect only at the edge that completes the write
	assign start = avs_write_in && ack && avs_address_in == `SME_AV_CTRL
		&& avs_writedata_in[`SME_AV_START] && state == sme_pkg::CPU_IDLE;

	always_comb
	begin
		next_state   = state;
		next_meth    = meth;
		next_slow    = slow;
		next_lowspd  = lowspd;
		next_step    = step;
		next_fetched = fetched;
		next_err     = err;
		next_done    = done;
		next_wr      = 1'b0;
		next_addr    = addr;
		next_wdata   = 8'h00;
		next_iflag   = iflag;
		next_halt    = 1'b0;
		case (state)
			sme_pkg::CPU_IDLE:
			begin
				if (start)
				begin
					next_meth   = sme_pkg::sme_method_e'(avs_writedata_in[`SME_AV_METH_LO +: 2]);
					next_slow   = avs_writedata_in[`SME_AV_SLOW];
					next_lowspd = avs_writedata_in[`SME_AV_LOWSPD];
					next_step   = 3'h0;
					next_err    = 1'b0;
					next_done   = 1'b0;
					next_state  = sme_pkg::CPU_STEP;
				end
			end
			sme_pkg::CPU_STEP:
			begin
				next_step = step + 3'h1;
				next_wr   = 1'b1;
				case (step)
					3'h0: next_addr = `SME_A_FLASH0;
					3'h1: next_addr = `SME_A_FLASH2;
					3'h2:
					begin
						next_addr = `SME_A_OSC;
						next_wr   = slow;
					end
					3'h3:
					begin
						next_addr  = `SME_A_VOLT;
						// Written every run so a later fast-mode wait does not inherit it
						next_wdata = {7'h00, lowspd && meth != sme_pkg::SME_STOP};
						next_wr    = 1'b1;
					end
					3'h4:
					begin
						next_addr  = `SME_A_PROTECT;
						next_wdata = 8'h01;
						next_wr    = meth != sme_pkg::SME_WAIT_INSTR;
						// Masked for register wait, open for halt entry
						next_iflag = meth != sme_pkg::SME_WAIT_REG;
					end
					default:
					begin
						next_addr    = (meth == sme_pkg::SME_STOP) ? `SME_A_CTRL1 : `SME_A_CTRL3;
						next_wdata   = 8'h01;
						next_wr      = meth != sme_pkg::SME_WAIT_INSTR;
						next_halt    = meth == sme_pkg::SME_WAIT_INSTR;
						next_fetched = 3'h0;
						next_state   = sme_pkg::CPU_FETCH;
					end
				endcase
			end
			sme_pkg::CPU_FETCH:
			begin
				// Fetch stands for the short jump and three no-op padding, four fetches in all
				if (link.fetch_req && link.fetch_grant)
					next_fetched = fetched + 3'h1;
				if (link.refused)
				begin
					next_err   = 1'b1;
					next_state = sme_pkg::CPU_IDLE;
				end
				else if (link.cpu_halted)
					next_state = sme_pkg::CPU_SLEEP;
			end
			sme_pkg::CPU_SLEEP:
			begin
				if (!link.cpu_halted)
				begin
					next_done  = meth != sme_pkg::SME_WAIT_REG;
					next_state = (meth == sme_pkg::SME_WAIT_REG) ? sme_pkg::CPU_POST1
						: sme_pkg::CPU_IDLE;
				end
			end
			sme_pkg::CPU_POST1:
			begin
				next_wr    = 1'b1;
				next_addr  = `SME_A_PROTECT;
				next_state = sme_pkg::CPU_POST2;
			end
			sme_pkg::CPU_POST2:
			begin
				next_iflag = 1'b1;
				next_done  = 1'b1;
				next_state = sme_pkg::CPU_IDLE;
			end
			default: next_state = sme_pkg::CPU_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state   <= sme_pkg::CPU_IDLE;
			meth    <= sme_pkg::SME_STOP;
			slow    <= 1'b0;
			lowspd  <= 1'b0;
			step    <= 3'h0;
			fetched <= 3'h0;
			err     <= 1'b0;
			done    <= 1'b0;
			wr      <= 1'b0;
			addr    <= 4'h0;
			wdata   <= 8'h00;
			iflag   <= 1'b0;
			halt    <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			meth    <= next_meth;
			slow    <= next_slow;
			lowspd  <= next_lowspd;
			step    <= next_step;
			fetched <= next_fetched;
			err     <= next_err;
			done    <= next_done;
			wr      <= next_wr;
			addr    <= next_addr;
			wdata   <= next_wdata;
			iflag   <= next_iflag;
			halt    <= next_halt;
		end
	end

	// One wait cycle per access keeps read data in a flop
	always_comb
	begin
		next_rdata = avs_readdata_out;
		if (avs_read_in && !ack)
			next_rdata = (avs_address_in == `SME_AV_STAT)
				? {28'h0000000, done, err, link.cpu_halted, state != sme_pkg::CPU_IDLE}
				: 32'h00000000;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			ack              <= 1'b0;
			avs_readdata_out <= 32'h00000000;
		end
		else
		begin
			ack              <= (avs_read_in || avs_write_in) && !ack;
			avs_readdata_out <= next_rdata;
		end
	end

	assign avs_waitrequest_out  = (avs_read_in || avs_write_in) && !ack;
	assign link.reg_wr          = wr;
	assign link.reg_addr        = addr;
	assign link.reg_wdata       = wdata;
	assign link.int_enable_flag = iflag;
	assign link.halt_instr      = halt;
	// No fetch while the request is still on the link, or the far end would miss a byte
	assign link.fetch_req       = (state == sme_pkg::CPU_FETCH) && !wr && !halt
		&& (fetched < `SME_PREFETCH);
endmodule // sme_cpu_end

//--- tb/sme_props.sv
// Checker for the link between the CPU end and the clock control end.
// Assumes the link signals, the shared clock and the reset as plain inputs.
`timescale 1ns/1ns
`include "sme_map.svh"
module sme_props (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       reg_wr,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       int_enable_flag,
	input  wire logic       halt_instr,
	input  wire logic       fetch_req,
	input  wire logic       fetch_grant,
	input  wire logic       cpu_halted,
	input  wire logic       refused
);
	logic       stop_set, wait_set;
	logic       rw_sh, lc_sh, unlock_sh, wreg;
	logic       next_rw, next_lc, next_unlock, next_wreg;
	logic [2:0] fcnt, next_fcnt;
	assign stop_set = reg_wr && reg_addr == `SME_A_CTRL1 && reg_wdata[`SME_B_STOP];
	assign wait_set = reg_wr && reg_addr == `SME_A_CTRL3 && reg_wdata[`SME_B_WAIT];
	// Shadows of the flash and protect bits as the CPU end has written them
	always_comb
	begin
		next_rw = rw_sh;
		next_lc = lc_sh;
		next_unlock = unlock_sh;
		next_wreg = wait_set ? 1'b1 : (int_enable_flag ? 1'b0 : wreg);
		if (reg_wr && reg_addr == `SME_A_FLASH0)
			next_rw = reg_wdata[`SME_B_REWRITE];
		if (reg_wr && reg_addr == `SME_A_FLASH2)
			next_lc = reg_wdata[`SME_B_LOWCUR];
		if (reg_wr && reg_addr == `SME_A_PROTECT)
			next_unlock = reg_wdata[`SME_B_UNLOCK];
		// Saturates so a runaway fetch stream cannot wrap back to a legal count
		next_fcnt = (stop_set || wait_set || halt_instr) ? 3'h0 : fcnt;
		if (fetch_req && fetch_grant && next_fcnt != 3'h7)
			next_fcnt = next_fcnt + 3'h1;
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			rw_sh <= 1'b0;
			lc_sh <= 1'b0;
			unlock_sh <= 1'b0;
			wreg <= 1'b0;
			fcnt <= 3'h0;
		end
		else
		begin
			rw_sh <= next_rw;
			lc_sh <= next_lc;
			unlock_sh <= next_unlock;
			wreg <= next_wreg;
			fcnt <= next_fcnt;
		end
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	chk_grant_halt: assert property (cpu_halted |-> !fetch_req && !fetch_grant)
		else $error("fetch while halted");
	chk_four_bytes: assert property ($rose(cpu_halted) |-> fcnt == 3'h4)
		else $error("halt without exactly four prefetches");
	chk_fetch_cap: assert property (fetch_req && fetch_grant |-> fcnt < 3'h4)
		else $error("more than four prefetches");
	chk_wait_reg_int: assert property (wait_set |-> !int_enable_flag)
		else $error("register wait entry with interrupts on");
	chk_halt_int: assert property (halt_instr |-> int_enable_flag)
		else $error("halt entry with interrupts off");
	chk_stop_flash: assert property (stop_set |-> !rw_sh)
		else $error("stop request with rewrite enabled");
	chk_wait_flash: assert property (wait_set || halt_instr |-> !rw_sh && !lc_sh)
		else $error("wait entry with a flash mode on");
	chk_unlock_first: assert property (stop_set || wait_set |-> unlock_sh)
		else $error("mode request while locked");
	chk_relock_first: assert property ($rose(int_enable_flag) && wreg |-> !unlock_sh)
		else $error("interrupts enabled before relock");
	chk_no_refusal: assert property (!refused)
		else $error("legal entry sequence refused");
endmodule // sme_props

//--- tb/standby_mode_entry_control_tb.sv
// Testbench: both ends joined by the link, driven over the Avalon-MM side.
// Assumes one 125 MHz clock and the register layout of sme_map.svh.
`timescale 1ns/1ns
`include "sme_map.svh"
module standby_mode_entry_control_tb;
	logic        ref_clk_in, rst_in, wake_irq_in, xin_fast_in, xin_stable_in;
	logic        cpu_clk_en, stop_mode, wait_mode, power_reduce, osc_stable, osc_stop_det;
	logic [1:0]  osd_enable;
	logic [3:0]  av_addr;
	logic        av_rd, av_wr, av_wait;
	logic [31:0] av_wdata, av_rdata, rd_val;
	int          err_count, n_compared;
	sme_if sme_if_i ();
	sme_clock_ctrl sme_clock_ctrl_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.link(sme_if_i.clk), .wake_irq_in(wake_irq_in), .xin_fast_in(xin_fast_in),
		.xin_stable_in(xin_stable_in), .cpu_clk_en_out(cpu_clk_en), .stop_mode_out(stop_mode),
		.wait_mode_out(wait_mode), .power_reduce_out(power_reduce), .osd_enable_out(osd_enable),
		.osc_stable_out(osc_stable), .osc_stop_det_out(osc_stop_det));
	sme_cpu_end sme_cpu_end_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(sme_if_i.cpu),
		.avs_address_in(av_addr), .avs_read_in(av_rd), .avs_write_in(av_wr),
		.avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata), .avs_waitrequest_out(av_wait));
	sme_props sme_props_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr(sme_if_i.reg_wr),
		.reg_addr(sme_if_i.reg_addr), .reg_wdata(sme_if_i.reg_wdata),
		.int_enable_flag(sme_if_i.int_enable_flag), .halt_instr(sme_if_i.halt_instr),
		.fetch_req(sme_if_i.fetch_req), .fetch_grant(sme_if_i.fetch_grant),
		.cpu_halted(sme_if_i.cpu_halted), .refused(sme_if_i.refused));
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge
	task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		av_addr <= a;
		av_wdata <= d;
		av_wr <= wr;
		av_rd <= !wr;
		do @(posedge ref_clk_in); while (av_wait !== 1'b0);
		rd_val = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	task automatic poll(input logic [31:0] mask, input logic [31:0] val);
		int n;
		n = 0;
		do
		begin
			av_xfer(1'b0, `SME_AV_STAT, 32'h0);
			n++;
		end
		while ((rd_val & mask) !== val && n < 60);
		check("status", rd_val & mask, val);
	endtask
	task automatic run(input logic [1:0] meth, input logic slow);
		logic [31:0] cmd;
		cmd = {27'h0, slow, slow, meth, 1'b1};
		av_xfer(1'b1, `SME_AV_CTRL, cmd);
		poll(32'h2, 32'h2);
		// A second start while halted must be ignored
		av_xfer(1'b1, `SME_AV_CTRL, cmd);
		@(negedge ref_clk_in);
		check("cpu clock off", cpu_clk_en, 1'b0);
		check("stop bit", stop_mode, meth == 2'h0);
		check("wait held", wait_mode, meth != 2'h0);
		check("power reduce", power_reduce, slow && meth != 2'h0);
		check("detect enable", osd_enable, 2'b00);
		@(posedge ref_clk_in);
		wake_irq_in <= 1'b1;
		@(posedge ref_clk_in);
		wake_irq_in <= 1'b0;
		poll(32'hF, 32'h8);
		check("cpu clock on", cpu_clk_en, 1'b1);
		check("stop cleared", stop_mode, 1'b0);
		check("wait cleared", wait_mode, 1'b0);
	endtask
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// Whole sequence needs a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge ref_clk_in);
		err_count++;
		end_of_test;
	end
	initial
	begin
		rst_in = 1'b1;
		wake_irq_in = 1'b0;
		xin_fast_in = 1'b1;
		xin_stable_in = 1'b1;
		av_addr = 4'h0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wdata = 32'h0;
		err_count = 0;
		n_compared = 0;
		repeat (20) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(negedge ref_clk_in);
		check("reset clock", cpu_clk_en, 1'b1);
		check("reset outputs", {stop_mode, wait_mode, osd_enable}, 4'h0);
		av_xfer(1'b0, `SME_AV_STAT, 32'h0);
		check("reset status", rd_val, 32'h0);
		av_xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
		av_xfer(1'b0, 4'h8, 32'h0);
		check("unmapped read", rd_val, 32'h0);
		for (int m = 0; m < 3; m++)
			for (int s = 0; s < 2; s++)
				run(m[1:0], s[0]);
		@(posedge ref_clk_in);
		xin_fast_in <= 1'b0;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		check("stable when slow", osc_stable, 1'b0);
		check("detect when slow", osc_stop_det, 1'b0);
		@(posedge ref_clk_in);
		xin_fast_in <= 1'b1;
		repeat (5) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		check("stable when fast", osc_stable, 1'b1);
		end_of_test;
	end
endmodule // standby_mode_entry_control_tb
